/* rtl/twdfp_pkg.sv */
package twdfp_pkg;
  // Overview of operation
  // - read-only 8-bit part identity register
  // - read-only 8-bit revision register at 0x01
  // - unlock programming by writing 0x02 then 0x01
  // - programming mode stays until system reset
  // - data register 0xB4 carries commands, addresses, data
  // - command 0x07 means flash block write
  // - accept 0x06 read, 0x08 page, 0x03 erase
  // - link traffic only while target is halted
  // - halted target borrows clock/reset and data pins
  // - shared user input stays still while halted
  // - reset pin is an input only
  // - data accesses target the selected register
  // - host clock plus bidirectional data line

  // link register map
  localparam logic [7:0] REG_PART_IDENTITY = 8'h00;
  localparam logic [7:0] REG_SILICON_REVISION = 8'h01;
  localparam logic [7:0] REG_FLASH_PROG_CONTROL = 8'h02;
  localparam logic [7:0] REG_FLASH_PROG_DATA = 8'hB4;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] UNLOCK_FIRST = 8'h02;
  localparam logic [7:0] UNLOCK_SECOND = 8'h01;

  // flash command codes
  localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
  localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
  localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;

  // link instructions, sent msb first after the start bit
  localparam logic [1:0] INS_ADDR_WR = 2'h0;
  localparam logic [1:0] INS_ADDR_RD = 2'h1;
  localparam logic [1:0] INS_DATA_WR = 2'h2;
  localparam logic [1:0] INS_DATA_RD = 2'h3;
  localparam logic [3:0] INS_LAST = 4'h1;
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam logic [3:0] FRAME_LAST = 4'hA;
  localparam logic [3:0] FIRST_DATA_BIT = 4'h3;

  // link timing
  localparam int SYS_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 400;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / SYS_PERIOD_NS / 2;

  // host controller registers
  localparam logic [2:0] HREG_COMMAND = 3'h0;
  localparam logic [2:0] HREG_TX_DATA = 3'h1;
  localparam logic [2:0] HREG_RX_DATA = 3'h2;
  localparam logic [2:0] HREG_STATUS = 3'h3;
  localparam logic [2:0] HREG_CONTROL = 3'h4;
  localparam int CMD_START_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int CTRL_TGT_RESET_BIT = 0;

  typedef enum logic [3:0] {
    DS_IDLE = 4'b0001,
    DS_INS = 4'b0010,
    DS_WR = 4'b0100,
    DS_RD = 4'b1000
  } twdfp_dev_state_type;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_RUN = 3'b010,
    HS_TAIL = 3'b100
  } twdfp_host_state_type;
endpackage

/* rtl/twdfp_link_if.sv */
`timescale 1ns/1ps
interface twdfp_link_if;
  logic clk_pin;
  logic h_data_out;
  logic h_data_oe;
  logic d_data_out;
  logic d_data_oe;
  logic data_level;

  // released line floats high through the pull-up
  assign data_level = h_data_oe ? h_data_out : (d_data_oe ? d_data_out : 1'b1);

  modport host (output clk_pin, output h_data_out, output h_data_oe, input data_level);
  modport target (input clk_pin, input data_level, output d_data_out, output d_data_oe);
endinterface

/* rtl/twdfp_target.sv */
`timescale 1ns/1ps
module twdfp_target #(
  parameter logic [7:0] PART_ID = 8'hA5, // arbitrary value
  parameter logic [7:0] REV_ID = 8'h5A // arbitrary value
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  twdfp_link_if.target LINK,
  input wire logic HALTED,
  input wire logic USER_DATA_OUT,
  input wire logic USER_DATA_OE,
  output logic USER_DATA_IN,
  output logic USER_RST_N,
  output logic PROG_EN,
  output logic FLASH_CMD_VALID,
  output logic [7:0] FLASH_CMD,
  output logic FLASH_BYTE_VALID,
  output logic [7:0] FLASH_BYTE,
  input wire logic FLASH_DONE,
  input wire logic FLASH_RD_VALID,
  input wire logic [7:0] FLASH_RD_DATA
);
  twdfp_pkg::twdfp_dev_state_type state_ff, nxt_state;
  logic ck_meta_ff, ck_sync_ff, ck_prev_ff;
  logic dt_meta_ff, dt_sync_ff;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [1:0] ins_ff, nxt_ins;
  logic drive_ff, nxt_drive;
  logic wr_done;
  logic [7:0] select_ff, ctl_ff, data_ff;
  logic armed_ff, prog_en_ff, expect_cmd_ff;
  logic pin_out_ff, pin_oe_ff;
  logic user_in_ff, user_rst_n_ff;
  logic cmd_valid_ff, byte_valid_ff;
  logic [7:0] cmd_ff, byte_ff;

  // edge and level decode on the synchronised pins
  wire ck_rise = ck_sync_ff & ~ck_prev_ff;
  wire ck_fall = ~ck_sync_ff & ck_prev_ff;
  wire [1:0] ins_shift = {ins_ff[0], dt_sync_ff};
  wire [7:0] wr_val = {shift_ff[6:0], dt_sync_ff};

  // register select decode
  wire sel_part = select_ff == twdfp_pkg::REG_PART_IDENTITY;
  wire sel_rev = select_ff == twdfp_pkg::REG_SILICON_REVISION;
  wire sel_ctl = select_ff == twdfp_pkg::REG_FLASH_PROG_CONTROL;
  wire sel_data = select_ff == twdfp_pkg::REG_FLASH_PROG_DATA;

  // read mux; unmapped selections read zero
  wire [7:0] data_mux = sel_part ? PART_ID :
                        sel_rev ? REV_ID :
                        sel_ctl ? ctl_ff :
                        sel_data ? data_ff : 8'h00;
  wire [7:0] rd_word = ins_shift[1] ? data_mux : select_ff;

  // write strobes out of finished write frames
  wire addr_wr = wr_done & (ins_ff == twdfp_pkg::INS_ADDR_WR);
  wire data_wr = wr_done & (ins_ff == twdfp_pkg::INS_DATA_WR);
  wire ctl_wr = data_wr & sel_ctl;
  wire fpd_wr = data_wr & sel_data;
  wire flash_wr = fpd_wr & prog_en_ff;
  wire cmd_known = (wr_val == twdfp_pkg::CMD_BLOCK_WRITE) |
                   (wr_val == twdfp_pkg::CMD_BLOCK_READ) |
                   (wr_val == twdfp_pkg::CMD_PAGE_ERASE) |
                   (wr_val == twdfp_pkg::CMD_DEVICE_ERASE);
  wire take_cmd = flash_wr & expect_cmd_ff & cmd_known;
  wire take_byte = flash_wr & ~expect_cmd_ff;

  // two-stage synchronisers; first stage feeds only the second
  always_ff @(posedge SYS_CLK)
  begin
    ck_meta_ff <= LINK.clk_pin;
    ck_sync_ff <= ck_meta_ff;
    ck_prev_ff <= ck_sync_ff;
    dt_meta_ff <= LINK.data_level;
    dt_sync_ff <= dt_meta_ff;
  end

  // frame sequencer: start, two instruction bits, eight data bits
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_ins = ins_ff;
    nxt_drive = drive_ff;
    wr_done = 1'b0;
    if (!HALTED)
    begin
      // link is dead unless halted, so a half frame is dropped
      nxt_state = twdfp_pkg::DS_IDLE;
      nxt_drive = 1'b0;
    end
    else
    begin
      case (state_ff)
        twdfp_pkg::DS_IDLE:
        begin
          if (ck_rise && !dt_sync_ff)
          begin
            nxt_state = twdfp_pkg::DS_INS;
            nxt_cnt = 4'h0;
          end
        end
        twdfp_pkg::DS_INS:
        begin
          if (ck_rise)
          begin
            nxt_ins = ins_shift;
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == twdfp_pkg::INS_LAST)
            begin
              nxt_cnt = 4'h0;
              nxt_state = ins_shift[0] ? twdfp_pkg::DS_RD : twdfp_pkg::DS_WR;
              nxt_shift = ins_shift[0] ? rd_word : 8'h00;
            end
          end
        end
        twdfp_pkg::DS_WR:
        begin
          if (ck_rise)
          begin
            nxt_shift = wr_val;
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == twdfp_pkg::DATA_LAST)
            begin
              wr_done = 1'b1;
              nxt_state = twdfp_pkg::DS_IDLE;
            end
          end
        end
        twdfp_pkg::DS_RD:
        begin
          // drive after falls so bits are stable at host rises
          if (ck_fall)
          begin
            if (!drive_ff)
              nxt_drive = 1'b1;
            else
              nxt_shift = {shift_ff[6:0], 1'b0};
          end
          if (ck_rise && drive_ff)
          begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == twdfp_pkg::DATA_LAST)
            begin
              nxt_drive = 1'b0;
              nxt_state = twdfp_pkg::DS_IDLE;
            end
          end
        end
        default:
        begin
          nxt_state = twdfp_pkg::DS_IDLE;
          nxt_drive = 1'b0;
        end
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state_ff <= twdfp_pkg::DS_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ins_ff <= twdfp_pkg::INS_ADDR_WR;
      drive_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      ins_ff <= nxt_ins;
      drive_ff <= nxt_drive;
    end
  end

  // select register changes only on an address write
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      select_ff <= twdfp_pkg::SELECT_RESET;
    else if (addr_wr)
      select_ff <= wr_val;
  end

  // unlock sequence; programming mode leaves only through reset
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ctl_ff <= twdfp_pkg::CONTROL_RESET;
      armed_ff <= 1'b0;
      prog_en_ff <= 1'b0;
    end
    else if (ctl_wr)
    begin
      ctl_ff <= wr_val;
      armed_ff <= wr_val == twdfp_pkg::UNLOCK_FIRST;
      if (armed_ff && wr_val == twdfp_pkg::UNLOCK_SECOND)
        prog_en_ff <= 1'b1;
    end
  end

  // data register; a host write beats a flash read return
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      data_ff <= twdfp_pkg::DATA_RESET;
    else if (fpd_wr)
      data_ff <= wr_val;
    else if (FLASH_RD_VALID)
      data_ff <= FLASH_RD_DATA;
  end

  // first accepted byte is a command, the rest go to the engine
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      expect_cmd_ff <= 1'b1;
      cmd_valid_ff <= 1'b0;
      byte_valid_ff <= 1'b0;
      cmd_ff <= 8'h00;
      byte_ff <= 8'h00;
    end
    else
    begin
      cmd_valid_ff <= take_cmd;
      byte_valid_ff <= take_byte;
      if (take_cmd)
        cmd_ff <= wr_val;
      if (take_byte)
        byte_ff <= wr_val;
      // done wins, the engine has already closed the command
      if (FLASH_DONE)
        expect_cmd_ff <= 1'b1;
      else if (take_cmd)
        expect_cmd_ff <= 1'b0;
    end
  end

  // pin ownership: link while halted, user function otherwise
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      pin_out_ff <= 1'b1;
      pin_oe_ff <= 1'b0;
      user_in_ff <= 1'b1;
      user_rst_n_ff <= 1'b1;
    end
    else
    begin
      pin_out_ff <= HALTED ? nxt_shift[7] : USER_DATA_OUT;
      pin_oe_ff <= HALTED ? nxt_drive : USER_DATA_OE;
      user_in_ff <= HALTED ? user_in_ff : dt_sync_ff;
      user_rst_n_ff <= HALTED ? 1'b1 : ck_sync_ff;
    end
  end

  assign LINK.d_data_out = pin_out_ff;
  assign LINK.d_data_oe = pin_oe_ff;
  assign USER_DATA_IN = user_in_ff;
  assign USER_RST_N = user_rst_n_ff;
  assign PROG_EN = prog_en_ff;
  assign FLASH_CMD_VALID = cmd_valid_ff;
  assign FLASH_CMD = cmd_ff;
  assign FLASH_BYTE_VALID = byte_valid_ff;
  assign FLASH_BYTE = byte_ff;
endmodule

/* rtl/twdfp_host.sv */
`timescale 1ns/1ps
module twdfp_host (
  input wire logic SYS_CLK,
  input wire logic RST,
  twdfp_link_if.host LINK,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA
);
  localparam logic [4:0] HALF_LAST = 5'(twdfp_pkg::LINK_HALF_CYC - 1);

  twdfp_pkg::twdfp_host_state_type state_ff, nxt_state;
  logic [4:0] div_ff, nxt_div;
  logic [3:0] slot_ff, nxt_slot;
  logic [9:0] frame_ff, nxt_frame;
  logic [7:0] tx_ff, rx_ff, nxt_rx, rdata_ff;
  logic rd_frame_ff, nxt_rd_frame;
  logic clk_ff, nxt_clk;
  logic out_ff, nxt_out;
  logic oe_ff, nxt_oe;
  logic done_ff, nxt_done;
  logic hold_rst_ff;
  logic dl_meta_ff, dl_sync_ff;

  // bus decode and frame bookkeeping
  wire tx_wr = WR & (ADDR == twdfp_pkg::HREG_TX_DATA);
  wire ctl_wr = WR & (ADDR == twdfp_pkg::HREG_CONTROL);
  wire start = WR & (ADDR == twdfp_pkg::HREG_COMMAND) & WDATA[twdfp_pkg::CMD_START_BIT];
  wire half_end = div_ff == HALF_LAST;
  wire [3:0] slot_inc = slot_ff + 4'h1;
  wire in_data = slot_inc >= twdfp_pkg::FIRST_DATA_BIT;
  wire busy = state_ff != twdfp_pkg::HS_IDLE;
  wire [7:0] status_word = (8'(busy) << twdfp_pkg::STAT_BUSY_BIT) |
                           (8'(done_ff) << twdfp_pkg::STAT_DONE_BIT);
  wire [7:0] control_word = 8'(hold_rst_ff) << twdfp_pkg::CTRL_TGT_RESET_BIT;

  // read mux; unmapped addresses read zero
  wire [7:0] rd_mux = (ADDR == twdfp_pkg::HREG_TX_DATA) ? tx_ff :
                      (ADDR == twdfp_pkg::HREG_RX_DATA) ? rx_ff :
                      (ADDR == twdfp_pkg::HREG_STATUS) ? status_word :
                      (ADDR == twdfp_pkg::HREG_CONTROL) ? control_word : 8'h00;

  // frame engine: data moves at clock falls, is sampled at rises
  always_comb
  begin
    nxt_state = state_ff;
    nxt_div = div_ff;
    nxt_slot = slot_ff;
    nxt_frame = frame_ff;
    nxt_rx = rx_ff;
    nxt_rd_frame = rd_frame_ff;
    nxt_clk = clk_ff;
    nxt_out = out_ff;
    nxt_oe = oe_ff;
    nxt_done = done_ff;
    case (state_ff)
      twdfp_pkg::HS_IDLE:
      begin
        // clock stands still between frames; held low it resets the target while it is not halted
        nxt_clk = ~hold_rst_ff;
        nxt_oe = 1'b0;
        if (start)
        begin
          nxt_state = twdfp_pkg::HS_RUN;
          nxt_div = 5'h00;
          nxt_slot = 4'h0;
          nxt_frame = {WDATA[1:0], tx_ff};
          nxt_rd_frame = WDATA[0];
          nxt_done = 1'b0;
          nxt_clk = 1'b0;
          nxt_out = 1'b0; // start bit
          nxt_oe = 1'b1;
        end
      end
      twdfp_pkg::HS_RUN:
      begin
        nxt_div = div_ff + 5'h01;
        if (half_end)
        begin
          nxt_div = 5'h00;
          if (!clk_ff)
          begin
            nxt_clk = 1'b1;
            if (rd_frame_ff && slot_ff >= twdfp_pkg::FIRST_DATA_BIT)
              nxt_rx = {rx_ff[6:0], dl_sync_ff};
          end
          else if (slot_ff == twdfp_pkg::FRAME_LAST)
          begin
            nxt_state = twdfp_pkg::HS_TAIL;
            nxt_oe = 1'b0;
          end
          else
          begin
            nxt_clk = 1'b0;
            nxt_slot = slot_inc;
            nxt_out = frame_ff[9];
            nxt_frame = {frame_ff[8:0], 1'b0};
            // released at the fall so the target finds a free line
            nxt_oe = ~(rd_frame_ff & in_data);
          end
        end
      end
      twdfp_pkg::HS_TAIL:
      begin
        // one idle half period lets the target finish its frame
        nxt_div = div_ff + 5'h01;
        if (half_end)
        begin
          nxt_div = 5'h00;
          nxt_state = twdfp_pkg::HS_IDLE;
          nxt_done = 1'b1;
        end
      end
      default:
      begin
        nxt_state = twdfp_pkg::HS_IDLE;
        nxt_oe = 1'b0;
      end
    endcase
  end

  // engine state
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state_ff <= twdfp_pkg::HS_IDLE;
      div_ff <= 5'h00;
      slot_ff <= 4'h0;
      frame_ff <= 10'h000;
      rx_ff <= 8'h00;
      rd_frame_ff <= 1'b0;
      clk_ff <= 1'b1;
      out_ff <= 1'b1;
      oe_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      div_ff <= nxt_div;
      slot_ff <= nxt_slot;
      frame_ff <= nxt_frame;
      rx_ff <= nxt_rx;
      rd_frame_ff <= nxt_rd_frame;
      clk_ff <= nxt_clk;
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      done_ff <= nxt_done;
    end
  end

  // software registers; read data stands one cycle after the strobe
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      tx_ff <= 8'h00;
      hold_rst_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end
    else
    begin
      if (tx_wr)
        tx_ff <= WDATA;
      if (ctl_wr)
        hold_rst_ff <= WDATA[twdfp_pkg::CTRL_TGT_RESET_BIT];
      if (RD)
        rdata_ff <= rd_mux;
    end
  end

  // data line comes from the pin, two stages before use
  always_ff @(posedge SYS_CLK)
  begin
    dl_meta_ff <= LINK.data_level;
    dl_sync_ff <= dl_meta_ff;
  end

  assign LINK.clk_pin = clk_ff;
  assign LINK.h_data_out = out_ff;
  assign LINK.h_data_oe = oe_ff;
  assign RDATA = rdata_ff;
endmodule

/* testbench/twdfp_link_checker.sv */
`timescale 1ns/1ps
module twdfp_link_checker (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic clk_pin,
  input wire logic h_data_out,
  input wire logic h_data_oe,
  input wire logic d_data_out,
  input wire logic d_data_oe
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  // drive windows are bounded so a stuck driver shows up
  sequence s_tgt_off;
    ##[1:400] !d_data_oe;
  endsequence
  sequence s_host_off;
    ##[1:1000] !h_data_oe;
  endsequence

  property p_one_driver;
    !(h_data_oe && d_data_oe);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("both ends drive data");

  property p_turn;
    $rose(d_data_oe) |-> !h_data_oe && !$past(h_data_oe);
  endproperty
  a_turn: assert property (p_turn) else $error("target drove without turnaround");

  property p_tgt_release;
    $rose(d_data_oe) |-> s_tgt_off;
  endproperty
  a_tgt_release: assert property (p_tgt_release) else $error("target kept data line");

  property p_host_release;
    $rose(h_data_oe) |-> s_host_off;
  endproperty
  a_host_release: assert property (p_host_release) else $error("host kept data line");

  // reset must free the line by the next cycle, so no disable here
  property p_rst_quiet;
    disable iff (1'b0) RST |=> !d_data_oe && !h_data_oe;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("line driven in reset");

  property p_clk_high;
    $rose(clk_pin) |-> clk_pin [*8];
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("link clock high too short");

  property p_clk_low;
    $fell(clk_pin) |-> !clk_pin [*8];
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("link clock low too short");

  property p_host_hold;
    clk_pin && $past(clk_pin) && h_data_oe && $past(h_data_oe) |-> $stable(h_data_out);
  endproperty
  a_host_hold: assert property (p_host_hold) else $error("host data moved in high phase");
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic halted = 1'b1;
  logic uout = 1'b0;
  logic fdone = 1'b0;
  logic [7:0] frd = 8'h00;
  logic pen;
  logic cv;
  logic bv;
  logic [7:0] cmd;
  logic [7:0] fb;
  logic [7:0] lcmd;
  logic [7:0] lb;
  logic [7:0] q;
  logic uin;
  logic urst;
  logic [31:0] seed = 32'h3;
  int fail_count = 0;
  int n_checks = 0;
  logic [7:0] cmds [4] = '{8'h06, 8'h07, 8'h08, 8'h03};
  localparam logic [7:0] PID = 8'h3C; // arbitrary value
  localparam logic [7:0] RID = 8'h4B; // arbitrary value

  twdfp_link_if lnk ();
  twdfp_host i_twdfp_host (.SYS_CLK(clk), .RST(rst), .LINK(lnk), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
  twdfp_target #(.PART_ID(PID), .REV_ID(RID)) i_twdfp_target (.SYS_CLK(clk), .RST(rst),
    .LINK(lnk), .HALTED(halted), .USER_DATA_OUT(uout), .USER_DATA_OE(1'b0),
    .USER_DATA_IN(uin), .USER_RST_N(urst), .PROG_EN(pen), .FLASH_CMD_VALID(cv),
    .FLASH_CMD(cmd),
    .FLASH_BYTE_VALID(bv), .FLASH_BYTE(fb), .FLASH_DONE(fdone), .FLASH_RD_VALID(fdone),
    .FLASH_RD_DATA(frd));
  twdfp_link_checker i_twdfp_link_checker (.SYS_CLK(clk), .RST(rst), .clk_pin(lnk.clk_pin),
    .h_data_out(lnk.h_data_out), .h_data_oe(lnk.h_data_oe), .d_data_out(lnk.d_data_out),
    .d_data_oe(lnk.d_data_oe));

  initial forever #12.5 clk = ~clk;

  // flash side closes a command after its data byte, with noise on user data out and flash read data
  always @(posedge clk)
  begin
    fdone <= bv;
    frd <= seed[7:0];
    uout <= seed[8];
    if (cv) lcmd <= cmd;
    if (bv) lb <= fb;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hw(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic hr(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // one link frame; busy poll is bounded, the watchdog covers the rest
  task automatic lop(input logic [1:0] ins, input logic [7:0] d);
    logic [7:0] s;
    hw(twdfp_pkg::HREG_TX_DATA, d);
    hw(twdfp_pkg::HREG_COMMAND, (8'h01 << twdfp_pkg::CMD_START_BIT) | {6'h00, ins});
    repeat (4) @(posedge clk);
    s = 8'hFF;
    for (int i = 0; i < 300 && s[twdfp_pkg::STAT_BUSY_BIT] !== 1'b0; i++)
      hr(twdfp_pkg::HREG_STATUS, s);
    hr(twdfp_pkg::HREG_RX_DATA, q);
  endtask

  task automatic reboot;
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  initial
  begin
    reboot();
    // identity reads, and a write to it must not stick
    lop(twdfp_pkg::INS_ADDR_WR, twdfp_pkg::REG_PART_IDENTITY);
    lop(twdfp_pkg::INS_DATA_WR, ~PID);
    lop(twdfp_pkg::INS_DATA_RD, 8'h00);
    chk("part_identity", PID, q);
    lop(twdfp_pkg::INS_ADDR_WR, twdfp_pkg::REG_SILICON_REVISION);
    lop(twdfp_pkg::INS_DATA_RD, 8'h00);
    chk("silicon_revision", RID, q);
    $display("test identity done");
    // random selects read back twice each
    repeat (4)
    begin
      seed = xs(seed);
      lop(twdfp_pkg::INS_ADDR_WR, seed[7:0]);
      repeat (2)
      begin
        lop(twdfp_pkg::INS_ADDR_RD, 8'h00);
        chk("register_select", seed[7:0], q);
      end
    end
    $display("test select done");
    // while running the pins belong to the user; reset pin is input only
    @(posedge clk);
    halted <= 1'b0;
    hw(twdfp_pkg::HREG_CONTROL, 8'h01);
    repeat (8) @(posedge clk);
    chk("user_rst_n", 8'h00, {7'h00, urst});
    chk("user_data_in", 8'h01, {7'h00, uin});
    hw(twdfp_pkg::HREG_CONTROL, 8'h00);
    repeat (8) @(posedge clk);
    chk("user_rst_n", 8'h01, {7'h00, urst});
    lop(twdfp_pkg::INS_ADDR_WR, ~seed[7:0]);
    @(posedge clk);
    halted <= 1'b1;
    lop(twdfp_pkg::INS_ADDR_RD, 8'h00);
    chk("register_select", seed[7:0], q);
    $display("test halt done");
    // unlock pair out of order first, then completed in order
    lop(twdfp_pkg::INS_ADDR_WR, twdfp_pkg::REG_FLASH_PROG_CONTROL);
    lop(twdfp_pkg::INS_DATA_RD, 8'h00);
    chk("flash_prog_control", twdfp_pkg::CONTROL_RESET, q);
    lop(twdfp_pkg::INS_DATA_WR, twdfp_pkg::UNLOCK_SECOND);
    lop(twdfp_pkg::INS_DATA_WR, twdfp_pkg::UNLOCK_FIRST);
    chk("prog_en", 8'h00, {7'h00, pen});
    lop(twdfp_pkg::INS_DATA_WR, twdfp_pkg::UNLOCK_SECOND);
    chk("prog_en", 8'h01, {7'h00, pen});
    lop(twdfp_pkg::INS_DATA_WR, 8'h00);
    chk("prog_en", 8'h01, {7'h00, pen});
    $display("test unlock done");
    // each command after a fresh reset, followed by one random byte
    foreach (cmds[k])
    begin
      reboot();
      chk("prog_en", 8'h00, {7'h00, pen});
      lop(twdfp_pkg::INS_ADDR_WR, twdfp_pkg::REG_FLASH_PROG_CONTROL);
      lop(twdfp_pkg::INS_DATA_WR, twdfp_pkg::UNLOCK_FIRST);
      lop(twdfp_pkg::INS_DATA_WR, twdfp_pkg::UNLOCK_SECOND);
      lop(twdfp_pkg::INS_ADDR_WR, twdfp_pkg::REG_FLASH_PROG_DATA);
      lop(twdfp_pkg::INS_DATA_WR, cmds[k]);
      chk("flash_cmd", cmds[k], lcmd);
      seed = xs(seed);
      lop(twdfp_pkg::INS_DATA_WR, seed[7:0]);
      chk("flash_byte", seed[7:0], lb);
    end
    $display("test commands done");
    wrap_up();
  end
endmodule
